// >>> core/edo_ctrl.sv
// Purpose: host controller driving an async edo dram through its pins
// Assumes: user holds req_i and its fields until ack_o
// Notes:   closed-row policy, early write only, cbr refresh only
// Function
// R1 - wait 200us, then eight refreshes before access
// R2 - early write keeps device outputs off
// R3 - late write gives read-modify-write
// R4 - avoid write enable between early and late
// R5 - read keeps write enable high past strobes
// R6 - late column strobe: access from column strobe
// R7 - late column address: access from address
// R8 - read drives bytes selected by strobes
// R9 - write lane only under its own strobe
// R10 - byte data setup/hold per own strobe
// R11 - early write data taken at strobe fall
// R12 - column address latched on first strobe
// R13 - read data ends at later strobe rise
// R14 - refresh every row within refresh period
// R15 - row strobe low at most 10us
// R16 - column strobe before row starts refresh
// R17 - long cbr hold enters self refresh
// R18 - full refresh burst around self refresh
// R19 - page precharge from last rise to fall
// R20 - device counter supplies cbr row address
// R21 - row strobe high means standby, data off
`timescale 1ns/1ps
module edo_ctrl
  import edo_pkg::*;
#(
  parameter int PWRUP_CYCLES = edo_pkg::PWRUP_CYC,
  parameter int SR_CYCLES    = edo_pkg::SR_ENTRY_CYC,
  parameter int ROWS         = edo_pkg::REF_ROWS,
  parameter int REF_INT      = edo_pkg::REF_INT_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      req_i,
  input  wire logic                      req_we_i,
  input  wire logic [1:0]                req_be_i,
  input  wire logic [edo_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [15:0]               req_wdata_i,
  input  wire logic                      sr_req_i,
  output logic                           ready_o,
  output logic                           ack_o,
  output logic [15:0]                    rdata_o,
  output logic                           sr_active_o,
  output logic                           ras_n_o,
  output logic                           lower_byte_col_strobe_n_o,
  output logic                           upper_byte_col_strobe_n_o,
  output logic                           we_n_o,
  output logic                           oe_n_o,
  output logic [edo_pkg::PIN_W-1:0]      address_pins_o,
  input  wire logic [15:0]               data_pins_i,
  output logic [15:0]                    data_pins_o,
  output logic                           data_pins_oe_o
);
  import edo_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  edo_state_t        state_ff;
  edo_state_t        nxt_state;
  logic [TMR_W-1:0]  tmr_val;
  logic              tmr_done;
  logic [3:0]        init_cnt_ff;
  logic [12:0]       burst_cnt_ff;
  logic [1:0]        sr_ph_ff;
  logic [TMR_W-1:0]  ref_cnt_ff;
  logic              ref_pend_ff;
  logic              pwr_arm_ff;
  logic              wr_ff;
  logic [1:0]        be_ff;
  logic [ADDR_W-1:0] addr_ff;

  wire init_done = (init_cnt_ff == 4'(INIT_REF_CNT));
  wire burst_end = (burst_cnt_ff == 13'(ROWS));
  wire ref_hit   = (ref_cnt_ff == TMR_W'(REF_INT - 1));
  wire cbr_go    = !init_done || ref_pend_ff || (sr_ph_ff != SR_OFF);      // [R1] [R14] [R18]
  wire take      = (state_ff == S_IDLE) && !cbr_go && !sr_req_i && req_i;
  wire cas_end   = (state_ff == S_CAS) && tmr_done;
  wire cbr_end   = (state_ff == S_CBR_RAS) && tmr_done;
  wire ras_low   = (nxt_state == S_ACT) || (nxt_state == S_COL) || (nxt_state == S_CAS) ||
                   (nxt_state == S_CBR_RAS) || (nxt_state == S_SR_HOLD);
  wire cbr_cas   = (nxt_state == S_CBR_CAS) || (nxt_state == S_CBR_RAS) || (nxt_state == S_SR_HOLD);
  wire acc_cas   = (nxt_state == S_CAS);
  wire col_ph    = (nxt_state == S_COL) || acc_cas;
  // addr_ff loads on the edge the row strobe falls, so the row comes from the request then
  wire [PIN_W-1:0] row_addr = take ? req_addr_i[ADDR_W-1:COL_W] : addr_ff[ADDR_W-1:COL_W];
  // one address setup cycle before the strobes fall, so both lanes see it [R12]
  wire [PIN_W-1:0] nxt_addr = (nxt_state == S_ACT) ? row_addr :
                              col_ph ? PIN_W'(addr_ff[COL_W-1:0]) : '0;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_PWR:     if (tmr_done && !pwr_arm_ff) nxt_state = S_CBR_CAS;       // [R1]
      S_IDLE:    if (cbr_go) nxt_state = S_CBR_CAS;
                 else if (take) nxt_state = S_ACT;
      S_ACT:     if (tmr_done) nxt_state = S_COL;
      S_COL:     if (tmr_done) nxt_state = S_CAS;
      S_CAS:     if (tmr_done) nxt_state = S_PRE;
      S_PRE:     if (tmr_done) nxt_state = S_IDLE;
      S_CBR_CAS: if (tmr_done) nxt_state = S_CBR_RAS;                      // [R16]
      S_CBR_RAS: if (tmr_done) nxt_state = (sr_ph_ff == SR_HOLD) ? S_SR_HOLD : S_PRE;
      S_SR_HOLD: if (tmr_done && !sr_req_i) nxt_state = S_PRE;             // [R17]
      default:   nxt_state = S_IDLE;
    endcase
  end

  always_comb
  begin
    case (nxt_state)
      S_PWR:     tmr_val = TMR_W'(PWRUP_CYCLES - 1);                       // [R1]
      S_ACT:     tmr_val = TMR_W'(T_RCD_CYC - 1);
      S_COL:     tmr_val = TMR_W'(COL_SETUP_CYC - 1);
      // strobe width covers the later of strobe and address access [R6] [R7]
      S_CAS:     tmr_val = TMR_W'(T_AA_CYC - 1);
      // closed row: every access ends in precharge, so column precharge is never shorter
      S_PRE:     tmr_val = (state_ff == S_SR_HOLD) ? TMR_W'(T_RPS_CYC - 1) : TMR_W'(T_RP_CYC - 1); // [R19]
      S_CBR_CAS: tmr_val = TMR_W'(T_CSR_CYC - 1);
      S_CBR_RAS: tmr_val = TMR_W'(T_RAS_CYC - 1);
      S_SR_HOLD: tmr_val = TMR_W'(SR_CYCLES - T_RAS_CYC - 1);
      default:   tmr_val = '0;
    endcase
  end

  // first cycle out of reset arms the power-up wait [R1]
  wire tmr_load = (nxt_state != state_ff) || pwr_arm_ff;

  edo_tmr #(
    .W      (TMR_W)
  ) u_tmr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .load_i (tmr_load),
    .val_i  (tmr_val),
    .done_o (tmr_done)
  );

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff    <= S_PWR;
      init_cnt_ff <= '0;
      ref_cnt_ff  <= '0;
      ref_pend_ff <= 1'b0;
      pwr_arm_ff  <= 1'b1;
    end
    else
    begin
      state_ff    <= nxt_state;
      pwr_arm_ff  <= 1'b0;
      init_cnt_ff <= (cbr_end && !init_done) ? init_cnt_ff + 4'h1 : init_cnt_ff;  // [R1]
      ref_cnt_ff  <= ref_hit ? '0 : ref_cnt_ff + 1'b1;
      // set wins over the clear taken when a refresh starts [R14]
      ref_pend_ff <= ref_hit || (ref_pend_ff && !(state_ff == S_IDLE && nxt_state == S_CBR_CAS));
    end
  end

  // ----------------------------------------------------------------
  // self refresh phases and burst count
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sr_ph_ff     <= SR_OFF;
      burst_cnt_ff <= '0;
    end
    else if (state_ff == S_IDLE && init_done && sr_ph_ff == SR_OFF && sr_req_i && !ref_pend_ff)
    begin
      sr_ph_ff     <= SR_PRE;
      burst_cnt_ff <= '0;
    end
    else if (state_ff == S_SR_HOLD && nxt_state == S_PRE)
    begin
      sr_ph_ff     <= SR_POST;
      burst_cnt_ff <= '0;
    end
    else if (cbr_end && (sr_ph_ff == SR_PRE || sr_ph_ff == SR_POST))
      burst_cnt_ff <= burst_cnt_ff + 13'h1;                                // [R18]
    else if (state_ff == S_IDLE && burst_end && sr_ph_ff == SR_PRE)
      sr_ph_ff     <= SR_HOLD;
    else if (state_ff == S_IDLE && burst_end && sr_ph_ff == SR_POST)
      sr_ph_ff     <= SR_OFF;
  end

  // ----------------------------------------------------------------
  // request capture and pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ff       <= 1'b0;
      be_ff       <= '0;
      addr_ff     <= '0;
      data_pins_o <= '0;
    end
    else if (take)
    begin
      wr_ff       <= req_we_i;
      be_ff       <= req_be_i;
      addr_ff     <= req_addr_i;
      data_pins_o <= req_wdata_i;                                          // [R10] [R11]
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ras_n_o                   <= 1'b1;
      lower_byte_col_strobe_n_o <= 1'b1;
      upper_byte_col_strobe_n_o <= 1'b1;
      we_n_o                    <= 1'b1;
      oe_n_o                    <= 1'b1;
      address_pins_o            <= '0;
      data_pins_oe_o            <= 1'b0;
      ready_o                   <= 1'b0;
      ack_o                     <= 1'b0;
      rdata_o                   <= '0;
      sr_active_o               <= 1'b0;
    end
    else
    begin
      ras_n_o                   <= !ras_low;                               // [R15] [R21]
      lower_byte_col_strobe_n_o <= !(cbr_cas || (acc_cas && be_ff[0]));    // [R8] [R9] [R16]
      upper_byte_col_strobe_n_o <= !(cbr_cas || (acc_cas && be_ff[1]));    // [R8] [R9] [R16]
      // we falls a cycle ahead of the strobes, never late, so no undefined cycle [R2] [R4] [R5]
      we_n_o                    <= !(col_ph && wr_ff);
      oe_n_o                    <= !(acc_cas && !wr_ff);
      address_pins_o            <= nxt_addr;                               // [R20]
      data_pins_oe_o            <= col_ph && wr_ff;
      ready_o                   <= (nxt_state == S_IDLE) && init_done && (sr_ph_ff == SR_OFF);
      ack_o                     <= cas_end;
      rdata_o                   <= (cas_end && !wr_ff) ? data_pins_i : rdata_o;
      sr_active_o               <= (nxt_state == S_SR_HOLD);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] ras_lo_cnt_ff;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ras_lo_cnt_ff <= '0;
    else
      ras_lo_cnt_ff <= ras_low ? ras_lo_cnt_ff + 1'b1 : '0;  // clear on the edge the strobe rises
  end
  wire any_cas_n = lower_byte_col_strobe_n_o && upper_byte_col_strobe_n_o;

  sequence cbr_setup_s;
    !lower_byte_col_strobe_n_o && !upper_byte_col_strobe_n_o && ras_n_o;
  endsequence

  early_write_a: assert property (@(posedge clk_i) disable iff (rst_i)  // [R2]
    $fell(any_cas_n) && !we_n_o |-> !$past(we_n_o) && oe_n_o)
    else $error("write enable not early before strobe");
  read_we_a: assert property (@(posedge clk_i) disable iff (rst_i)      // [R5]
    !oe_n_o |-> we_n_o ##1 we_n_o)
    else $error("write enable low during read");
  read_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)    // [R8]
    !oe_n_o |-> !data_pins_oe_o && !any_cas_n)
    else $error("read without strobe or with drive");
  write_lane_a: assert property (@(posedge clk_i) disable iff (rst_i)   // [R9]
    data_pins_oe_o |-> !we_n_o && oe_n_o && !ras_n_o)
    else $error("data driven outside write");
  cbr_order_a: assert property (@(posedge clk_i) disable iff (rst_i)    // [R16]
    $fell(ras_n_o) && !any_cas_n |-> !$past(lower_byte_col_strobe_n_o) && !$past(upper_byte_col_strobe_n_o))
    else $error("cbr without strobe setup");
  cbr_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)      // [R16]
    cbr_setup_s ##1 (!ras_n_o && !any_cas_n) |-> ##1 !ras_n_o)
    else $error("cbr row strobe too short");
  cas_pre_a: assert property (@(posedge clk_i) disable iff (rst_i)      // [R19]
    $rose(any_cas_n) |-> ##1 any_cas_n)
    else $error("column precharge too short");
  init_ref_a: assert property (@(posedge clk_i) disable iff (rst_i)     // [R1]
    $rose(ready_o) |-> init_cnt_ff == 4'(INIT_REF_CNT))
    else $error("access before eight refreshes");
  ras_max_a: assert property (@(posedge clk_i) disable iff (rst_i)      // [R15]
    !sr_active_o && state_ff != S_SR_HOLD && state_ff != S_CBR_RAS |-> ras_lo_cnt_ff < TMR_W'(RAS_LOW_MAX_CYC))
    else $error("row strobe low too long");
  sr_min_a: assert property (@(posedge clk_i) disable iff (rst_i)       // [R17]
    $rose(ras_n_o) && $past(state_ff) == S_SR_HOLD |-> ras_lo_cnt_ff == '0 && $past(ras_lo_cnt_ff) >= TMR_W'(SR_CYCLES - 1))
    else $error("self refresh left early");
  sr_burst_a: assert property (@(posedge clk_i) disable iff (rst_i)     // [R18]
    $rose(sr_active_o) |-> sr_ph_ff == SR_HOLD)
    else $error("self refresh without burst");
  ref_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)     // [R14]
    $rose(ref_pend_ff) && init_done && sr_ph_ff == SR_OFF |-> ##[1:40] !ref_pend_ff)
    else $error("refresh not served in time");

endmodule // edo_ctrl

// >>> core/edo_pkg.sv
// Purpose: shared constants and types for the edo memory controller
// Assumes: 100 MHz clock; 1M x16 part with 4096 refresh rows
// Notes:   times are kept in their own unit, cycle counts derive from them except COL_SETUP_CYC, given in cycles
package edo_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int TMR_W          = 16;
  localparam int T_RCD_NS       = 20;
  localparam int T_AA_NS        = 35;
  localparam int T_RP_NS        = 50;
  localparam int T_RPS_NS       = 130;
  localparam int T_CSR_NS       = 5;
  localparam int T_RAS_NS       = 70;
  localparam int T_RCD_CYC      = (T_RCD_NS * CLK_MHZ + 999) / 1000;
  localparam int T_AA_CYC       = (T_AA_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RP_CYC       = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RPS_CYC      = (T_RPS_NS * CLK_MHZ + 999) / 1000;
  localparam int T_CSR_CYC      = (T_CSR_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RAS_CYC      = (T_RAS_NS * CLK_MHZ + 999) / 1000;
  localparam int COL_SETUP_CYC  = 1;
  localparam int RAS_LOW_MAX_NS = 10000;
  localparam int RAS_LOW_MAX_CYC = RAS_LOW_MAX_NS * CLK_MHZ / 1000;

  // ----------------------------------------------------------------
  // power-up, refresh and self refresh
  // ----------------------------------------------------------------
  localparam int PWRUP_US       = 200;
  localparam int PWRUP_CYC      = PWRUP_US * CLK_MHZ;
  localparam int SR_ENTRY_US    = 100;
  localparam int SR_ENTRY_CYC   = SR_ENTRY_US * CLK_MHZ;
  localparam int INIT_REF_CNT   = 8;
  localparam int REF_ROWS       = 4096;
  localparam int REF_PERIOD_MS  = 64;
  localparam int REF_INT_CYC    = REF_PERIOD_MS * 1000 * CLK_MHZ / REF_ROWS;

  // ----------------------------------------------------------------
  // geometry and phases
  // ----------------------------------------------------------------
  localparam int ADDR_W         = 20;
  localparam int PIN_W          = 12;
  localparam int COL_W          = 8;
  localparam logic [1:0] SR_OFF  = 2'h0;
  localparam logic [1:0] SR_PRE  = 2'h1;
  localparam logic [1:0] SR_HOLD = 2'h2;
  localparam logic [1:0] SR_POST = 2'h3;

  typedef enum logic [3:0] {
    S_PWR     = 4'h0,
    S_IDLE    = 4'h1,
    S_ACT     = 4'h2,
    S_COL     = 4'h3,
    S_CAS     = 4'h4,
    S_PRE     = 4'h5,
    S_CBR_CAS = 4'h6,
    S_CBR_RAS = 4'h7,
    S_SR_HOLD = 4'h8
  } edo_state_t;

endpackage

// >>> core/edo_tmr.sv
// Purpose: down counter timing each controller phase
// Assumes: load has priority over counting
// Notes:   done_o is high while the count sits at zero
`timescale 1ns/1ps
module edo_tmr #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] val_i,
  output logic              done_o
);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_ff <= '0;
    else if (load_i)
      cnt_ff <= val_i;
    else if (cnt_ff != '0)
      cnt_ff <= cnt_ff - 1'b1;
  end

  // no load term: the caller derives load from done, which would close a loop
  assign done_o = (cnt_ff == '0);

endmodule // edo_tmr

// >>> tb/edo_mem_model.sv
// Purpose: behavioural edo memory answering the controller's pins
// Assumes: sparse storage, no setup or hold timing checks
// Notes:   a released lane shows the inverse of the stored word
`timescale 1ns/1ps
module edo_mem_model (
  input  wire logic        ras_n_i,
  input  wire logic [1:0]  cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [11:0] address_pins_i,
  input  wire logic [15:0] data_pins_i,
  output logic [15:0]      data_pins_o,
  output logic [1:0]       lane_on_o,
  output int               ref_cnt_o
);
  // ----------------------------------------------------------------
  // row, column and refresh tracking
  // ----------------------------------------------------------------
  logic [15:0] mem [int];
  logic [11:0] row_ff;
  logic [11:0] ref_row_ff = 12'h000;
  logic [7:0]  col_ff;
  logic        col_open   = 1'b0;
  logic        colref     = 1'b0;
  logic [19:0] idx;
  logic [15:0] rd;
  int          refs       = 0;

  assign ref_cnt_o = refs;
  assign idx       = {row_ff, col_open ? col_ff : address_pins_i[7:0]};

  always @(negedge ras_n_i)
  begin
    #1;  // let the row address launched with the strobe settle
    colref = !(&cas_n_i);
    if (colref)
    begin
      refs++;
      ref_row_ff = ref_row_ff + 12'h001;
    end
    else
      row_ff = address_pins_i;
  end

  always @(cas_n_i)
    if (&cas_n_i)
      col_open = 1'b0;
    else if (!ras_n_i && !col_open)
    begin
      col_ff   = address_pins_i[7:0];
      col_open = 1'b1;
    end

  // sensitive to strobes too, since the store changes under a fixed index
  always @(idx or cas_n_i or ras_n_i or we_n_i)
    rd = mem.exists(idx) ? mem[idx] : 16'h0000;

  // ----------------------------------------------------------------
  // per-lane write capture and read drive
  // ----------------------------------------------------------------
  for (genvar l = 0; l < 2; l++)
  begin : g_lane
    logic [15:0] w;
    // early write takes data at strobe fall, late write at enable fall
    always @(negedge cas_n_i[l] or negedge we_n_i)
      if (!ras_n_i && !we_n_i && !cas_n_i[l] && !colref)
      begin
        w             = mem.exists(idx) ? mem[idx] : 16'h0000;
        w[8*l +: 8]   = data_pins_i[8*l +: 8];
        mem[idx]      = w;
      end
    always @*
      if (ras_n_i && cas_n_i[l])
        lane_on_o[l] = 1'b0;
      else if (!ras_n_i && !cas_n_i[l] && !oe_n_i && we_n_i && !colref)
        lane_on_o[l] = 1'b1;
      else if (oe_n_i || !we_n_i)
        lane_on_o[l] = 1'b0;
    assign data_pins_o[8*l +: 8] = lane_on_o[l] ? rd[8*l +: 8] : ~rd[8*l +: 8];
  end
endmodule // edo_mem_model

// >>> tb/test_edo_ctrl.sv
// Purpose: self-checking bench for the edo controller
// Assumes: shortened power-up, self refresh and refresh counts
// Notes:   expected data kept in a bench shadow copy
`timescale 1ns/1ps
module test_edo_ctrl;
  import edo_pkg::*;
  // ----------------------------------------------------------------
  // setup
  // ----------------------------------------------------------------
  localparam int PWR = 20, SRC = 20, ROWS = 4, RINT = 200;
  logic              clk_i = 1'b0, rst_i = 1'b1, req_i = 1'b0, req_we_i = 1'b0, sr_req_i = 1'b0;
  logic [1:0]        req_be_i = 2'h0, cas_n, lane_on, be;
  logic [ADDR_W-1:0] req_addr_i = 20'h00000;
  logic [15:0]       req_wdata_i = 16'h0000, rdata_o, dq_ctl, dq_mem, data_pins, q, d;
  logic              ready_o, ack_o, sr_active_o, ras_n, we_n, oe_n, dq_oe, gap_on = 1'b0, in_sr = 1'b0;
  logic [11:0]       address_pins;
  logic [19:0]       pool [4];
  logic [15:0]       shadow [4];
  int                bad_count = 0, check_count = 0, ref_cnt, cyc = 0, first_ras = -1, ready_ref = -1;
  int                ras_run = 0, ras_max = 0, sr_run = 0, clash = 0, gap = 0, gap_max = 0, seen = 0;
  int                k, n, r0;

  always #5 clk_i = ~clk_i;
  assign data_pins = dq_oe ? dq_ctl : dq_mem;

  edo_ctrl #(.PWRUP_CYCLES(PWR), .SR_CYCLES(SRC), .ROWS(ROWS), .REF_INT(RINT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .req_we_i(req_we_i), .req_be_i(req_be_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .sr_req_i(sr_req_i), .ready_o(ready_o),
    .ack_o(ack_o), .rdata_o(rdata_o), .sr_active_o(sr_active_o), .ras_n_o(ras_n),
    .lower_byte_col_strobe_n_o(cas_n[0]), .upper_byte_col_strobe_n_o(cas_n[1]), .we_n_o(we_n),
    .oe_n_o(oe_n), .address_pins_o(address_pins), .data_pins_i(data_pins), .data_pins_o(dq_ctl),
    .data_pins_oe_o(dq_oe));

  edo_mem_model u_mem (.ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .address_pins_i(address_pins), .data_pins_i(data_pins), .data_pins_o(dq_mem),
    .lane_on_o(lane_on), .ref_cnt_o(ref_cnt));

  // ----------------------------------------------------------------
  // pin monitor
  // ----------------------------------------------------------------
  always @(posedge clk_i)
    if (!rst_i)
    begin
      cyc++;
      if (first_ras < 0 && !ras_n) first_ras = cyc;
      if (ready_ref < 0 && ready_o) ready_ref = ref_cnt;
      if (sr_active_o) in_sr = 1'b1;
      if (!ras_n) ras_run++;
      else if (ras_run > 0)
      begin
        if (in_sr) sr_run = ras_run;
        else if (ras_run > ras_max) ras_max = ras_run;
        ras_run = 0;
        in_sr   = 1'b0;
      end
      if (dq_oe && |lane_on) clash++;
      gap  = (ref_cnt != seen) ? 0 : gap + 1;
      seen = ref_cnt;
      if (gap_on && gap > gap_max) gap_max = gap;
    end

  // ----------------------------------------------------------------
  // tasks and expectation helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lanes(input logic [1:0] b);
    return {{8{b[1]}}, {8{b[0]}}};
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      cmp("wait bound", 0, 1);
      test_done();
    end
  endtask

  // request held until ack, then spaced by the precharge count
  task automatic access(input logic we, input logic [1:0] b, input logic [19:0] a,
                        input logic [15:0] wd, output logic [15:0] rq);
    int c;
    {req_we_i, req_be_i, req_addr_i, req_wdata_i, req_i} = {we, b, a, wd, 1'b1};
    for (c = 0; c < 1000 && ack_o !== 1'b1; c++)
    begin
      @(posedge clk_i);
      #1;
    end
    rq = rdata_o;
    tmo(c, 1000);
    req_i = 1'b0;
    repeat (T_RP_CYC) @(posedge clk_i);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(19));
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      pool[i]   = (i == 0) ? 20'hfffff : (i == 1) ? 20'h00000 : {18'($urandom), 2'(i - 1)};
      shadow[i] = 16'($urandom);
      access(1'b1, 2'h3, pool[i], shadow[i], q);
    end
    cmp("power-up wait", 1, 32'(first_ras > PWR));
    cmp("refreshes before ready", 8, ready_ref);
    for (int i = 0; i < 40; i++)
    begin
      k  = $urandom_range(3);
      be = 2'($urandom_range(3, 1));
      d  = 16'($urandom);
      if ($urandom_range(1) == 1)
      begin
        access(1'b1, be, pool[k], d, q);
        shadow[k] = (shadow[k] & ~lanes(be)) | (d & lanes(be));
      end
      else
      begin
        access(1'b0, be, pool[k], 16'h0000, q);
        cmp("read lanes", 32'(shadow[k] & lanes(be)), 32'(q & lanes(be)));
      end
    end
    cmp("bus clash cycles", 0, clash);
    gap_on = 1'b1;
    repeat (4 * RINT) @(posedge clk_i);
    gap_on = 1'b0;
    cmp("refresh gap", 1, 32'(gap_max <= RINT + 13));
    cmp("row strobe low", 1, 32'(ras_max < RAS_LOW_MAX_CYC));
    r0 = ref_cnt;
    #1 sr_req_i = 1'b1;
    for (n = 0; n < 2000 && sr_active_o !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    tmo(n, 2000);
    cmp("burst before hold", 1, 32'(ref_cnt - r0 >= ROWS));
    cmp("ready in hold", 0, 32'(ready_o));
    r0 = ref_cnt;
    repeat (SRC + 10) @(posedge clk_i);
    #1 sr_req_i = 1'b0;
    for (n = 0; n < 2000 && ready_o !== 1'b1; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    tmo(n, 2000);
    cmp("hold length", 1, 32'(sr_run >= SRC));
    cmp("burst after hold", 1, 32'(ref_cnt - r0 >= ROWS));
    access(1'b0, 2'h3, pool[0], 16'h0000, q);
    cmp("word after hold", 32'(shadow[0]), 32'(q));
    test_done();
  end
endmodule // test_edo_ctrl
